/* verilog/ecc_pkg.sv */
// Constants, codes and helpers for the external copy counter interface.
// How it works
// - Each counted sheet pulses total and key counter count outputs low together.
// - Large-size setting 1, 2 or 3 doubles only the key counter pulse for large sheets.
// - Coin controller or key card: copy allowed only while permit input is low.
// - Key counter: copy allowed only while presence input is low, else prompt.
// - Copy running goes low at least 30 ms before the total pulse starts.
// - Copy running returns high no sooner than 50 ms after exit pulse ends.
// - While copying is interrupted, copy running stays high until resumable.
// - Each exit sensor turn-on drives the exit count pulse low for 200 ms.
// - With each total pulse exactly one mode count pulse fires, 200 ms long.
// - The second count of a double count gets no mode count pulse.
// - Size lines carry A3 0100, A4 0101, A5-R 0110, B4 1100, B5 1101, else 0000.
// - Large paper output low for large size or unsized manual feed, else high.
// - Full colour mode output low while full colour selected, low after reset.
// - Twin/mono mode output low while twin or mono colour is selected.
// - Black mode output low while black mode is selected.
// - Selection: 0 none, 1 coin, 2 copy key card, 3 key counter, 4 alt card.
// - Copy key card selection is valid only when the region setting holds 2.
package ecc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int LEAD_MS = 30;
  localparam int TAIL_MS = 50;
  localparam int EXIT_PULSE_MS = 200;
  localparam int MODE_PULSE_MS = 200;
  localparam int COUNT_PULSE_MS = 100;
  localparam int DOUBLE_GAP_MS = 100;
  localparam int EXIT_PULSE_CYC = EXIT_PULSE_MS * MS_CYC;
  localparam int MODE_PULSE_CYC = MODE_PULSE_MS * MS_CYC;
  localparam int COUNT_PULSE_CYC = COUNT_PULSE_MS * MS_CYC;
  localparam int DOUBLE_GAP_CYC = DOUBLE_GAP_MS * MS_CYC;
  // One extra tick covers the unknown phase of the millisecond divider.
  localparam logic [7:0] LEAD_TICKS = 8'(LEAD_MS + 1);
  localparam logic [7:0] TAIL_TICKS = 8'(TAIL_MS + 1);
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_COIN = 3'h1;
  localparam logic [2:0] SEL_KEYCARD = 3'h2;
  localparam logic [2:0] SEL_KEYCTR = 3'h3;
  localparam logic [2:0] SEL_ALTCARD = 3'h4;
  localparam logic [3:0] REGION_KEYCARD = 4'h2;
  localparam logic [1:0] DBL_SINGLE = 2'h0;
  localparam logic [3:0] PEND_MAX = 4'hf;
  typedef enum logic [1:0] {
    MODE_FULL = 2'h0,
    MODE_TWIN = 2'h1,
    MODE_MONO = 2'h2,
    MODE_BLACK = 2'h3
  } ecc_mode_e;
  typedef enum logic [2:0] {
    PAPER_OTHER = 3'h0,
    PAPER_A3 = 3'h1,
    PAPER_A4 = 3'h2,
    PAPER_A5R = 3'h3,
    PAPER_B4 = 3'h4,
    PAPER_B5 = 3'h5
  } ecc_paper_e;
  localparam logic [3:0] SIZE_A3 = 4'h4;
  localparam logic [3:0] SIZE_A4 = 4'h5;
  localparam logic [3:0] SIZE_A5R = 4'h6;
  localparam logic [3:0] SIZE_B4 = 4'hc;
  localparam logic [3:0] SIZE_B5 = 4'hd;
  localparam logic [3:0] SIZE_OTHER = 4'h0;

  function automatic logic [3:0] ecc_size_code(input ecc_paper_e p);
    case (p)
      PAPER_A3: ecc_size_code = SIZE_A3;
      PAPER_A4: ecc_size_code = SIZE_A4;
      PAPER_A5R: ecc_size_code = SIZE_A5R;
      PAPER_B4: ecc_size_code = SIZE_B4;
      PAPER_B5: ecc_size_code = SIZE_B5;
      default: ecc_size_code = SIZE_OTHER;
    endcase
  endfunction
endpackage

/* verilog/ecc_ms_tick.sv */
// Millisecond enable pulse divided down from the system clock.
`timescale 1ns/1ns
module ecc_ms_tick #(
  parameter int DIV = 100000
) (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic tick
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

/* verilog/ecc_pulse.sv */
// Retriggerable one-shot that stays active for an exact number of cycles.
`timescale 1ns/1ns
module ecc_pulse #(
  parameter int LEN = 20000000
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic kill,
  output logic active
);
  localparam int W = $clog2(LEN + 1);
  localparam logic [W-1:0] LOAD = W'(LEN - 1);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      active <= 1'b0;
    end
    else if (kill)
    begin
      cnt_q <= '0;
      active <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= LOAD;
      active <= 1'b1;
    end
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
    else
      active <= 1'b0;
  end
endmodule

/* verilog/ecc_counter_if.sv */
// Output and input logic toward an external coin, key card or key counter.
`timescale 1ns/1ns
module ecc_counter_if #(
  parameter int MS_DIV = ecc_pkg::MS_CYC,
  parameter int EXIT_CYC = ecc_pkg::EXIT_PULSE_CYC,
  parameter int MODE_CYC = ecc_pkg::MODE_PULSE_CYC,
  parameter int COUNT_CYC = ecc_pkg::COUNT_PULSE_CYC,
  parameter int GAP_CYC = ecc_pkg::DOUBLE_GAP_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] ctr_select,
  input wire logic [3:0] region_setting,
  input wire logic [1:0] large_count_setting,
  input wire ecc_pkg::ecc_mode_e copy_mode,
  input wire ecc_pkg::ecc_paper_e paper_size,
  input wire logic large_selected,
  input wire logic manual_no_size,
  input wire logic copy_active,
  input wire logic copy_interrupted,
  input wire logic sheet_count_event,
  input wire logic exit_sensor_event,
  input wire logic copy_permit_in_n,
  input wire logic keyctr_present_in_n,
  output logic copy_allowed,
  output logic set_counter_prompt,
  output logic total_count_pulse_n,
  output logic keyctr_count_pulse_n,
  output logic copy_running_out_n,
  output logic exit_count_pulse_n,
  output logic black_count_pulse_n,
  output logic mono_count_pulse_n,
  output logic fullcolor_count_pulse_n,
  output logic size_code_bit3,
  output logic size_code_bit2,
  output logic size_code_bit1,
  output logic size_code_bit0,
  output logic large_paper_out_n,
  output logic fullcolor_mode_out_n,
  output logic twin_mono_mode_out_n,
  output logic black_mode_out_n
);
  import ecc_pkg::*;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FIRST = 4'h2,
    ST_GAP = 4'h4,
    ST_SECOND = 4'h8
  } ecc_state_e;
  ecc_state_e state_q, state_d;
  logic permit_m_q, permit_s_q, present_m_q, present_s_q;
  logic en_q, sel_valid, allowed_d, ms_tick, run_q, run_d, busy, dbl_q;
  logic [3:0] pend_q, size_q;
  logic [7:0] lead_q, tail_q;
  ecc_mode_e pulse_mode_q;
  logic fire, start_key, start_gap, total_act, key_act, mode_act;
  logic exit_act, gap_act, large_q, full_q, twin_q, black_q;
  // Permission lines come from the outside world and are synchronised first.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      permit_m_q <= 1'b1;
      permit_s_q <= 1'b1;
      present_m_q <= 1'b1;
      present_s_q <= 1'b1;
    end
    else
    begin
      permit_m_q <= copy_permit_in_n;
      permit_s_q <= permit_m_q;
      present_m_q <= keyctr_present_in_n;
      present_s_q <= present_m_q;
    end
  end
  // An unknown selection, or the copy key card outside its region, acts as
  // no counter at all rather than half-enabling the signal set.
  always_comb
  begin
    case (ctr_select)
      SEL_COIN, SEL_KEYCTR, SEL_ALTCARD: sel_valid = 1'b1;
      SEL_KEYCARD: sel_valid = (region_setting == REGION_KEYCARD);
      default: sel_valid = 1'b0;
    endcase
  end
  always_comb
  begin
    if (!sel_valid)
      allowed_d = 1'b1;
    else if (ctr_select == SEL_KEYCTR)
      allowed_d = !present_s_q;
    else
      allowed_d = !permit_s_q;
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_q <= 1'b0;
      copy_allowed <= 1'b1;
      set_counter_prompt <= 1'b0;
    end
    else
    begin
      en_q <= sel_valid;
      copy_allowed <= allowed_d;
      set_counter_prompt <= !allowed_d;
    end
  end
  ecc_ms_tick #(.DIV(MS_DIV)) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(ms_tick)
  );
  // Sheets counted before the lead time has passed wait here, so up to 15
  // counts are kept when the engine reports sheets faster than the pulses run.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      pend_q <= '0;
    else if (!en_q)
      pend_q <= '0;
    else if (sheet_count_event && !fire && pend_q != PEND_MAX)
      pend_q <= pend_q + 1'b1;
    else if (fire && !sheet_count_event)
      pend_q <= pend_q - 1'b1;
  end
  always_comb
  begin
    state_d = state_q;
    fire = 1'b0;
    start_key = 1'b0;
    start_gap = 1'b0;
    case (state_q)
      ST_IDLE:
        if (pend_q != '0 && run_q && lead_q == LEAD_TICKS && !mode_act)
        begin
          fire = 1'b1;
          state_d = ST_FIRST;
        end
      ST_FIRST:
        if (!total_act && !key_act)
        begin
          start_gap = dbl_q;
          state_d = dbl_q ? ST_GAP : ST_IDLE;
        end
      ST_GAP:
        if (!gap_act)
        begin
          start_key = 1'b1;
          state_d = ST_SECOND;
        end
      ST_SECOND:
        if (!key_act)
          state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else if (!en_q)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end
  // Only a large sheet with setting 1, 2 or 3 earns a second key counter pulse.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dbl_q <= 1'b0;
      pulse_mode_q <= MODE_FULL;
    end
    else if (fire)
    begin
      dbl_q <= large_selected && (large_count_setting != DBL_SINGLE);
      pulse_mode_q <= copy_mode;
    end
  end
  ecc_pulse #(.LEN(COUNT_CYC)) u_total (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(fire),
    .kill(!en_q),
    .active(total_act)
  );
  ecc_pulse #(.LEN(COUNT_CYC)) u_key (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(fire || start_key),
    .kill(!en_q),
    .active(key_act)
  );
  ecc_pulse #(.LEN(GAP_CYC)) u_gap (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(start_gap),
    .kill(!en_q),
    .active(gap_act)
  );
  // The mode pulse starts only from the first count of a sheet.
  ecc_pulse #(.LEN(MODE_CYC)) u_mode (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(fire),
    .kill(!en_q),
    .active(mode_act)
  );
  ecc_pulse #(.LEN(EXIT_CYC)) u_exit (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(exit_sensor_event && en_q),
    .kill(!en_q),
    .active(exit_act)
  );
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tail_q <= '0;
    else if (exit_act)
      tail_q <= TAIL_TICKS;
    else if (ms_tick && tail_q != '0)
      tail_q <= tail_q - 1'b1;
  end
  // Unless copying is interrupted, refused or disabled, the running window closes only once nothing of the sheet is left over.
  assign busy = (pend_q != '0) || (state_q != ST_IDLE) || total_act ||
                key_act || mode_act || exit_act || (tail_q != '0);
  assign run_d = en_q && copy_allowed && !copy_interrupted &&
                 (copy_active || busy);
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      run_q <= 1'b0;
    else
      run_q <= run_d;
  end
  // The lead count restarts whenever the window reopens after a pause.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      lead_q <= '0;
    else if (!run_q)
      lead_q <= '0;
    else if (ms_tick && lead_q != LEAD_TICKS)
      lead_q <= lead_q + 1'b1;
  end
  // Static level outputs follow the panel selection every cycle while a valid counter is selected.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      size_q <= SIZE_OTHER;
      large_q <= 1'b0;
      full_q <= 1'b1;
      twin_q <= 1'b0;
      black_q <= 1'b0;
    end
    else
    begin
      size_q <= en_q ? ecc_size_code(paper_size) : SIZE_OTHER;
      large_q <= en_q && (large_selected || manual_no_size);
      full_q <= en_q && copy_mode == MODE_FULL;
      twin_q <= en_q && (copy_mode == MODE_TWIN ||
                         copy_mode == MODE_MONO);
      black_q <= en_q && copy_mode == MODE_BLACK;
    end
  end
  assign total_count_pulse_n = !total_act;
  assign keyctr_count_pulse_n = !key_act;
  assign copy_running_out_n = !run_q;
  assign exit_count_pulse_n = !exit_act;
  assign black_count_pulse_n =
    !(mode_act && pulse_mode_q == MODE_BLACK);
  assign mono_count_pulse_n = !(mode_act && (pulse_mode_q == MODE_TWIN ||
                                pulse_mode_q == MODE_MONO));
  assign fullcolor_count_pulse_n =
    !(mode_act && pulse_mode_q == MODE_FULL);
  assign {size_code_bit3, size_code_bit2, size_code_bit1,
          size_code_bit0} = size_q;
  assign large_paper_out_n = !large_q;
  assign fullcolor_mode_out_n = !full_q;
  assign twin_mono_mode_out_n = !twin_q;
  assign black_mode_out_n = !black_q;
  sequence s_total_start;
    $fell(total_count_pulse_n);
  endsequence
  sequence s_second_count;
    $fell(keyctr_count_pulse_n) && total_count_pulse_n;
  endsequence
  property p_total_key_together;
    @(posedge mclk) disable iff (sys_rst)
    s_total_start |-> $fell(keyctr_count_pulse_n);
  endproperty
  a_total_key_together: assert property (p_total_key_together)
    else $error("total and key counter pulses did not start together");
  property p_second_only_double;
    @(posedge mclk) disable iff (sys_rst)
    s_second_count |-> dbl_q && large_count_setting != DBL_SINGLE;
  endproperty
  a_second_only_double: assert property (p_second_only_double)
    else $error("second key counter pulse without double count");
  property p_permit_blocks;
    @(posedge mclk) disable iff (sys_rst)
    en_q && sel_valid && ctr_select != SEL_KEYCTR && permit_s_q
      |=> !copy_allowed && set_counter_prompt ##1 copy_running_out_n;
  endproperty
  a_permit_blocks: assert property (p_permit_blocks)
    else $error("copy not blocked while permit input is high");
  property p_present_blocks;
    @(posedge mclk) disable iff (sys_rst)
    ctr_select == SEL_KEYCTR && present_s_q |=> !copy_allowed;
  endproperty
  a_present_blocks: assert property (p_present_blocks)
    else $error("copy not blocked while key counter is absent");
  property p_lead_time;
    @(posedge mclk) disable iff (sys_rst)
    s_total_start |-> $past(lead_q) == LEAD_TICKS && $past(run_q);
  endproperty
  a_lead_time: assert property (p_lead_time)
    else $error("total pulse started before the running lead time");
  property p_tail_time;
    @(posedge mclk) disable iff (sys_rst)
    $rose(copy_running_out_n) && !$past(copy_interrupted) && $past(en_q)
      && $past(copy_allowed) |-> $past(tail_q) == '0 && $past(!exit_act);
  endproperty
  a_tail_time: assert property (p_tail_time)
    else $error("copy running released too soon after exit pulse");
  property p_interrupt_high;
    @(posedge mclk) disable iff (sys_rst)
    copy_interrupted [*2] |-> copy_running_out_n;
  endproperty
  a_interrupt_high: assert property (p_interrupt_high)
    else $error("copy running low while copying is interrupted");
  property p_exit_start;
    @(posedge mclk) disable iff (sys_rst)
    exit_sensor_event && en_q |=> !exit_count_pulse_n [*2];
  endproperty
  a_exit_start: assert property (p_exit_start)
    else $error("exit pulse did not start on exit sensor event");
  property p_one_mode_pulse;
    @(posedge mclk) disable iff (sys_rst)
    s_total_start |-> $onehot({!black_count_pulse_n, !mono_count_pulse_n,
                               !fullcolor_count_pulse_n});
  endproperty
  a_one_mode_pulse: assert property (p_one_mode_pulse)
    else $error("not exactly one mode pulse with the total pulse");
  property p_no_second_mode;
    @(posedge mclk) disable iff (sys_rst)
    s_second_count |-> black_count_pulse_n && mono_count_pulse_n &&
                       fullcolor_count_pulse_n;
  endproperty
  a_no_second_mode: assert property (p_no_second_mode)
    else $error("mode pulse issued for the second count");
  property p_disabled_quiet;
    @(posedge mclk) disable iff (sys_rst)
    !sel_valid [*3] |-> total_count_pulse_n && exit_count_pulse_n &&
      copy_running_out_n && large_paper_out_n && copy_allowed;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("interface active while no counter is selected");
endmodule

/* bench/ecc_far_counter.sv */
// Behavioural external counter that counts pulses and drives permit pins.
`timescale 1ns/1ns
module ecc_far_counter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] pins_n,
  input wire logic deny,
  input wire logic attached,
  output logic copy_permit_in_n,
  output logic keyctr_present_in_n,
  output logic [7:0] cnt [6],
  output logic [15:0] wid [6]
);
  logic [15:0] run [6];
  logic [5:0] prev_q;
  // The permit pins are plain levels, so a refusing counter just holds them.
  assign copy_permit_in_n = deny;
  assign keyctr_present_in_n = !attached;
  // Permit and presence pins follow deny and attached separately; pins count on falling edges.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (sys_rst)
      begin
        cnt[i] <= 8'h00;
        wid[i] <= 16'h0000;
        run[i] <= 16'h0000;
        prev_q[i] <= 1'b1;
      end
      else
      begin
        prev_q[i] <= pins_n[i];
        if (!pins_n[i])
          run[i] <= (prev_q[i] ? 16'h0001 : run[i] + 16'h0001);
        if (prev_q[i] && !pins_n[i])
          cnt[i] <= cnt[i] + 8'h01;
        if (!prev_q[i] && pins_n[i])
          wid[i] <= run[i];
      end
    end
  end
endmodule

/* bench/ecc_counter_if_bench.sv */
// Self-checking bench for the external copy counter interface.
`timescale 1ns/1ns
module ecc_counter_if_bench;
  import ecc_pkg::*;
  localparam int DIV = 10;
  localparam int LEAD_CYC = LEAD_MS * DIV;
  localparam int TAIL_CYC = TAIL_MS * DIV;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] ctr_select = 3'h0;
  logic [3:0] region_setting = 4'h0;
  logic [1:0] large_count_setting = 2'h0;
  ecc_mode_e copy_mode = MODE_FULL;
  ecc_paper_e paper_size = PAPER_OTHER;
  logic large_selected = 1'b0;
  logic manual_no_size = 1'b0;
  logic copy_active = 1'b0;
  logic copy_interrupted = 1'b0;
  logic sheet_count_event = 1'b0;
  logic exit_sensor_event = 1'b0;
  logic deny = 1'b1;
  logic attached = 1'b0;
  logic copy_permit_in_n, keyctr_present_in_n, copy_allowed;
  logic set_counter_prompt, total_count_pulse_n, keyctr_count_pulse_n;
  logic copy_running_out_n, exit_count_pulse_n, black_count_pulse_n;
  logic mono_count_pulse_n, fullcolor_count_pulse_n, size_code_bit3;
  logic size_code_bit2, size_code_bit1, size_code_bit0, large_paper_out_n;
  logic fullcolor_mode_out_n, twin_mono_mode_out_n, black_mode_out_n;
  logic [5:0] pins_n;
  logic [7:0] cnt [6];
  logic [15:0] wid [6];
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_run = 0;
  logic run_prev = 1'b1;
  assign pins_n = {fullcolor_count_pulse_n, mono_count_pulse_n,
    black_count_pulse_n, exit_count_pulse_n, keyctr_count_pulse_n,
    total_count_pulse_n};
  ecc_counter_if #(.MS_DIV(DIV), .EXIT_CYC(200), .MODE_CYC(200),
    .COUNT_CYC(100), .GAP_CYC(100)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .ctr_select(ctr_select), .region_setting(region_setting),
    .large_count_setting(large_count_setting), .copy_mode(copy_mode),
    .paper_size(paper_size), .large_selected(large_selected),
    .manual_no_size(manual_no_size), .copy_active(copy_active),
    .copy_interrupted(copy_interrupted),
    .sheet_count_event(sheet_count_event),
    .exit_sensor_event(exit_sensor_event),
    .copy_permit_in_n(copy_permit_in_n),
    .keyctr_present_in_n(keyctr_present_in_n), .copy_allowed(copy_allowed),
    .set_counter_prompt(set_counter_prompt),
    .total_count_pulse_n(total_count_pulse_n),
    .keyctr_count_pulse_n(keyctr_count_pulse_n),
    .copy_running_out_n(copy_running_out_n),
    .exit_count_pulse_n(exit_count_pulse_n),
    .black_count_pulse_n(black_count_pulse_n),
    .mono_count_pulse_n(mono_count_pulse_n),
    .fullcolor_count_pulse_n(fullcolor_count_pulse_n),
    .size_code_bit3(size_code_bit3), .size_code_bit2(size_code_bit2),
    .size_code_bit1(size_code_bit1), .size_code_bit0(size_code_bit0),
    .large_paper_out_n(large_paper_out_n),
    .fullcolor_mode_out_n(fullcolor_mode_out_n),
    .twin_mono_mode_out_n(twin_mono_mode_out_n),
    .black_mode_out_n(black_mode_out_n));
  ecc_far_counter far (.mclk(mclk), .sys_rst(sys_rst), .pins_n(pins_n),
    .deny(deny), .attached(attached), .copy_permit_in_n(copy_permit_in_n),
    .keyctr_present_in_n(keyctr_present_in_n), .cnt(cnt), .wid(wid));
  always #5 mclk = ~mclk;
  // The fall of the running line is timed in the same settled slot as the
  // bench samples, so the lead figure is not skewed by one cycle.
  always @(posedge mclk)
  begin
    cyc++;
    #1;
    if (run_prev === 1'b1 && copy_running_out_n === 1'b0)
      t_run = cyc;
    run_prev = copy_running_out_n;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic idle_none;
    ctr_select = 3'h0;
    copy_active = 1'b1;
    sheet_count_event = 1'b1;
    tick(1);
    sheet_count_event = 1'b0;
    tick(600);
    check(16'(cnt[0]), 16'h0);
    check(16'({pins_n, copy_running_out_n, large_paper_out_n,
      fullcolor_mode_out_n, twin_mono_mode_out_n, black_mode_out_n}),
      16'h07ff);
    check(16'(copy_allowed), 16'h1);
    copy_active = 1'b0;
  endtask
  task automatic levels;
    ctr_select = SEL_COIN;
    for (int m = 0; m < 4; m++)
    begin
      copy_mode = ecc_mode_e'(m);
      tick(3);
      check(16'({fullcolor_mode_out_n, twin_mono_mode_out_n,
        black_mode_out_n}), 16'({m != 0, m != 1 && m != 2, m != 3}));
    end
    for (int i = 0; i < 4; i++)
    begin
      {large_selected, manual_no_size} = 2'(i);
      tick(3);
      check(16'(large_paper_out_n), 16'(i == 0));
    end
    {large_selected, manual_no_size} = 2'h0;
  endtask
  task automatic sizes;
    logic [3:0] codes [6];
    codes = '{4'h0, 4'h4, 4'h5, 4'h6, 4'hc, 4'hd};
    ctr_select = SEL_KEYCARD;
    region_setting = REGION_KEYCARD;
    large_count_setting = DBL_SINGLE;
    for (int p = 0; p < 6; p++)
    begin
      paper_size = ecc_paper_e'(p);
      tick(3);
      check(16'({size_code_bit3, size_code_bit2, size_code_bit1,
        size_code_bit0}), 16'(codes[p]));
    end
  endtask
  task automatic count_sheet(input int m, input logic dbl, input int pin);
    logic [7:0] c0 [6];
    int k;
    c0 = cnt;
    copy_mode = ecc_mode_e'(m);
    large_count_setting = {1'b0, dbl};
    large_selected = dbl;
    copy_active = 1'b1;
    tick(2);
    sheet_count_event = 1'b1;
    tick(1);
    sheet_count_event = 1'b0;
    k = 0;
    while (total_count_pulse_n !== 1'b0 && k < 2000)
    begin
      tick(1);
      k++;
    end
    check(16'(keyctr_count_pulse_n), 16'h0);
    check(16'(pins_n[pin]), 16'h0);
    check(16'(copy_running_out_n), 16'h0);
    check(16'(cyc - t_run >= LEAD_CYC), 16'h1);
    tick(900);
    check(16'(cnt[0] - c0[0]), 16'h1);
    check(16'(cnt[1] - c0[1]), 16'(dbl ? 2 : 1));
    check(16'(cnt[pin] - c0[pin]), 16'h1);
    check(16'(cnt[3] + cnt[4] + cnt[5] - c0[3] - c0[4] - c0[5]), 16'h1);
    check(wid[pin], 16'd200);
    check(wid[0], 16'd100);
  endtask
  task automatic exit_tail;
    int k;
    copy_active = 1'b1;
    exit_sensor_event = 1'b1;
    tick(1);
    exit_sensor_event = 1'b0;
    check(16'(exit_count_pulse_n), 16'h0);
    k = 0;
    while (exit_count_pulse_n !== 1'b1 && k < 1000)
    begin
      tick(1);
      k++;
    end
    copy_active = 1'b0;
    tick(1);
    check(wid[2], 16'd200);
    k = 0;
    while (copy_running_out_n !== 1'b1 && k < 2000)
    begin
      tick(1);
      k++;
    end
    check(16'(k + 1 >= TAIL_CYC && k < 2000), 16'h1);
  endtask
  task automatic interrupt;
    copy_active = 1'b1;
    tick(3);
    check(16'(copy_running_out_n), 16'h0);
    copy_interrupted = 1'b1;
    tick(3);
    check(16'(copy_running_out_n), 16'h1);
    copy_interrupted = 1'b0;
    tick(3);
    check(16'(copy_running_out_n), 16'h0);
  endtask
  task automatic try_permit(input logic [2:0] s, input logic [3:0] r,
    input logic d, input logic a, input logic exp);
    ctr_select = s;
    region_setting = r;
    deny = d;
    attached = a;
    tick(6);
    check(16'(copy_allowed), 16'(exp));
    check(16'(set_counter_prompt), 16'(!exp));
    if (!exp)
      check(16'(copy_running_out_n), 16'h1);
  endtask
  initial
  begin
    tick(1);
    check(16'(fullcolor_mode_out_n), 16'h0);
    tick(1);
    sys_rst = 1'b0;
    idle_none();
    levels();
    sizes();
    ctr_select = SEL_COIN;
    deny = 1'b0;
    count_sheet(0, 1'b0, 5);
    count_sheet(1, 1'b0, 4);
    count_sheet(2, 1'b0, 4);
    count_sheet(3, 1'b0, 3);
    ctr_select = SEL_KEYCTR;
    attached = 1'b1;
    count_sheet(3, 1'b1, 3);
    ctr_select = SEL_COIN;
    exit_tail();
    interrupt();
    try_permit(SEL_COIN, 4'h0, 1'b1, 1'b1, 1'b0);
    try_permit(SEL_COIN, 4'h0, 1'b0, 1'b1, 1'b1);
    try_permit(SEL_KEYCTR, 4'h0, 1'b0, 1'b0, 1'b0);
    try_permit(SEL_KEYCTR, 4'h0, 1'b1, 1'b1, 1'b1);
    try_permit(SEL_KEYCARD, 4'h1, 1'b1, 1'b1, 1'b1);
    try_permit(SEL_KEYCARD, 4'h2, 1'b1, 1'b1, 1'b0);
    try_permit(SEL_ALTCARD, 4'h0, 1'b1, 1'b1, 1'b0);
    try_permit(SEL_NONE, 4'h0, 1'b1, 1'b0, 1'b1);
    print_verdict();
  end
  // Far longer than the whole sequence, which needs under 10000 cycles.
  initial
  begin
    #500000;
    num_errors++;
    print_verdict();
  end
endmodule
